// >>> hw/pin_sync.v
`timescale 1ns/10ps
`default_nettype none

// Three-stage input synchroniser; output moves when stages two and three agree
module pin_sync
#(
	parameter W = 8
)
(
	input  wire         clk_i,   // System clock
	input  wire         reset_i, // Synchronous reset
	input  wire [W-1:0] pin_i,   // Asynchronous pins
	output reg  [W-1:0] sync_o   // Filtered, clock-domain value
);

	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;

	// ****************************************
	// Sync chain
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1)
		begin : bit_g
			// Agreement of stages two and three filters single-cycle glitches
			always @(posedge clk_i)
			begin
				if (reset_i)
				begin
					s1_r[g]   <= 1'b1;
					s2_r[g]   <= 1'b1;
					s3_r[g]   <= 1'b1;
					sync_o[g] <= 1'b1;
				end
				else
				begin
					s1_r[g] <= pin_i[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g])
						sync_o[g] <= s3_r[g];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// >>> hw/prog_ctrl_regs.vh
`ifndef PROG_CTRL_REGS_VH
`define PROG_CTRL_REGS_VH

// Clock rate in kHz
`define CLK_KHZ            25000
// Times in ns
`define T_SETUP_NS         2000
`define T_PULSE_MIN_NS     95000
`define T_PULSE_NOM_NS     100000
`define T_PULSE_MAX_NS     105000
`define T_HOLD_NS          2000
`define T_OE_VALID_NS      100
`define T_OE_HIZ_NS        130
// Cycle counts: minimums round up, the nominal pulse sits inside 95..105 us
// Pulse math goes through microseconds: ns times kHz would overflow a signed 32-bit integer
`define SETUP_CYC   (((`T_SETUP_NS * `CLK_KHZ) + 999999) / 1000000)
`define PULSE_CYC   (((`T_PULSE_NOM_NS / 1000) * `CLK_KHZ) / 1000)
// Extra read wait for the three-stage input synchroniser
`define SYNC_CYC    3
`define HOLD_CYC    (((`T_HOLD_NS * `CLK_KHZ) + 999999) / 1000000)
`define OEV_CYC     (((`T_OE_VALID_NS * `CLK_KHZ) + 999999) / 1000000)
`define HIZ_CYC     (((`T_OE_HIZ_NS * `CLK_KHZ) + 999999) / 1000000)
// Pulse cap per byte
`define MAX_PULSES         8'd25
// Widths
`define ADDR_W             15
`define DATA_W             8
// Signature byte addresses (byte-select line is address bit 0)
`define SIG_ADDR_MFR       15'h0000
`define SIG_ADDR_DEV       15'h0001
// Operation codes
`define OP_PROGRAM         2'h0
`define OP_VERIFY          2'h1
`define OP_SIGNATURE       2'h2

`endif

// >>> hw/prom_programmer.v
`timescale 1ns/10ps
`default_nettype none
`include "prog_ctrl_regs.vh"

// Overview of operation
// - Program mode: high supply, select low
// - Program pulse between 95 and 105 us
// - Repeat 100 us pulses until verify passes, at most 25 per byte
// - Select high inhibits programming of device
// - Verify: read drive low, select high
// - Setup 2 us before select falls
// - Data held 2 us around pulse/verify
// - Signature: high voltage id line, others low
module prom_programmer
(
	input  wire        clk_i,          // 25 MHz clock
	input  wire        reset_i,        // Synchronous reset, active high
	input  wire        start_i,        // Pulse: begin operation
	input  wire [1:0]  op_i,           // Operation code
	input  wire [14:0] addr_i,         // Byte address
	input  wire [7:0]  wdata_i,        // Byte to write
	output reg         busy_o,         // Operation in progress
	output reg         done_o,         // Pulse: operation finished
	output reg         fail_o,         // With done: pulse cap reached
	output reg  [7:0]  rdata_o,        // Verify or signature byte
	output reg  [7:0]  pulses_o,       // Pulses used on last byte
	output reg         chip_sel_n_o,   // Chip select, active low
	output reg         read_drv_n_o,   // Read drive, active low
	output reg  [14:0] addr_o,         // Address lines
	input  wire [7:0]  data_lines_i,   // Data lines from device
	output reg  [7:0]  data_lines_o,   // Data lines to device
	output reg         data_lines_oe_o, // High while we drive data lines
	output reg         vpp_high_o,     // Program supply at 12.75 V
	output reg         vcc_high_o,     // Core supply at 6.25 V
	output reg         id_high_voltage_line_o // Id line forced to 12 V
);

	// ****************************************
	// States
	// ****************************************
	localparam [7:0] S_IDLE  = 8'h01;
	localparam [7:0] S_SETUP = 8'h02;
	localparam [7:0] S_PULSE = 8'h04;
	localparam [7:0] S_HOLD  = 8'h08;
	localparam [7:0] S_READ  = 8'h10;
	localparam [7:0] S_HIZ   = 8'h20;
	localparam [7:0] S_CHECK = 8'h40;
	localparam [7:0] S_DONE  = 8'h80;

	// Counts worked out as integers, then cut to the counter width on purpose
	localparam integer SETUP_I = `SETUP_CYC;
	localparam integer PULSE_I = `PULSE_CYC;
	localparam integer HOLD_I  = `HOLD_CYC;
	localparam integer OEV_I   = `OEV_CYC + `SYNC_CYC; // Extra cycles cover 3-stage input sync
	localparam integer HIZ_I   = `HIZ_CYC;

	localparam [11:0] SETUP_N = SETUP_I[11:0];
	localparam [11:0] PULSE_N = PULSE_I[11:0];
	localparam [11:0] HOLD_N  = HOLD_I[11:0];
	localparam [11:0] OEV_N   = OEV_I[11:0];
	localparam [11:0] HIZ_N   = HIZ_I[11:0];

	reg [7:0]  state_r;
	reg [11:0] cnt_r;
	reg [1:0]  op_r;
	reg [7:0]  wdata_r;

	wire [7:0] rd_sync;

	// Three-stage sync of the device's data lines
	pin_sync #(.W(8)) u_sync
	(
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.pin_i   (data_lines_i),
		.sync_o  (rd_sync)
	);

	// Verify passes only when the byte read back equals the byte asked for
	function verify_ok;
		input [7:0] want;
		input [7:0] got;
		begin
			verify_ok = ((got & ~want) == 8'h00) && (got == want);
		end
	endfunction

	// ****************************************
	// Sequencer
	// ****************************************
	// Supplies raise on a program or verify start in IDLE and stay up across pulse/verify loops;
	// each retry still goes back through SETUP and waits its count again.
	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_r <= S_IDLE;
			cnt_r <= 12'h000;
			op_r <= 2'h0;
			wdata_r <= 8'hff;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
			rdata_o <= 8'hff;
			pulses_o <= 8'h00;
			chip_sel_n_o <= 1'b1;
			read_drv_n_o <= 1'b1;
			addr_o <= 15'h0000;
			data_lines_o <= 8'hff;
			data_lines_oe_o <= 1'b0;
			vpp_high_o <= 1'b0;
			vcc_high_o <= 1'b0;
			id_high_voltage_line_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			case (state_r)
			S_IDLE:
			begin
				if (start_i)
				begin
					busy_o <= 1'b1;
					fail_o <= 1'b0;
					op_r <= op_i;
					wdata_r <= wdata_i;
					pulses_o <= 8'h00;
					cnt_r <= 12'h000;
					if (op_i == `OP_SIGNATURE)
					begin
						// Only the byte-select bit may be high
						addr_o <= {14'h0000, addr_i[0]};
						id_high_voltage_line_o <= 1'b1;
						vpp_high_o <= 1'b0;
						vcc_high_o <= 1'b0;
						data_lines_oe_o <= 1'b0;
					end
					else
					begin
						addr_o <= addr_i;
						vpp_high_o <= 1'b1;
						vcc_high_o <= 1'b1;
						data_lines_o <= wdata_i;
						data_lines_oe_o <= (op_i == `OP_PROGRAM);
					end
					state_r <= S_SETUP;
				end
			end
			S_SETUP:
			begin
				// Everything settled before select falls or read drive drops
				if (cnt_r >= SETUP_N - 12'd1)
				begin
					cnt_r <= 12'h000;
					if (op_r == `OP_PROGRAM)
					begin
						chip_sel_n_o <= 1'b0;
						pulses_o <= pulses_o + 8'd1;
						state_r <= S_PULSE;
					end
					else
					begin
						chip_sel_n_o <= (op_r != `OP_SIGNATURE);
						read_drv_n_o <= 1'b0;
						state_r <= S_READ;
					end
				end
				else
					cnt_r <= cnt_r + 12'd1;
			end
			S_PULSE:
			begin
				if (cnt_r >= PULSE_N - 12'd1)
				begin
					chip_sel_n_o <= 1'b1;
					cnt_r <= 12'h000;
					state_r <= S_HOLD;
				end
				else
					cnt_r <= cnt_r + 12'd1;
			end
			S_HOLD:
			begin
				// Data stays on the lines after select rises, then released
				if (cnt_r >= HOLD_N - 12'd1)
				begin
					data_lines_oe_o <= 1'b0;
					read_drv_n_o <= 1'b0;
					cnt_r <= 12'h000;
					state_r <= S_READ;
				end
				else
					cnt_r <= cnt_r + 12'd1;
			end
			S_READ:
			begin
				if (cnt_r >= OEV_N - 12'd1)
				begin
					rdata_o <= rd_sync;
					read_drv_n_o <= 1'b1;
					chip_sel_n_o <= 1'b1;
					cnt_r <= 12'h000;
					state_r <= S_HIZ;
				end
				else
					cnt_r <= cnt_r + 12'd1;
			end
			S_HIZ:
			begin
				// Wait for the device to let go before we drive again
				if (cnt_r >= HIZ_N - 12'd1)
				begin
					cnt_r <= 12'h000;
					state_r <= S_CHECK;
				end
				else
					cnt_r <= cnt_r + 12'd1;
			end
			S_CHECK:
			begin
				if (op_r != `OP_PROGRAM)
					state_r <= S_DONE;
				else if (verify_ok(wdata_r, rdata_o))
					state_r <= S_DONE;
				else if (pulses_o >= `MAX_PULSES)
				begin
					fail_o <= 1'b1;
					state_r <= S_DONE;
				end
				else
				begin
					// Another pulse; data back on the lines first
					data_lines_oe_o <= 1'b1;
					state_r <= S_SETUP;
				end
			end
			S_DONE:
			begin
				vpp_high_o <= 1'b0;
				vcc_high_o <= 1'b0;
				id_high_voltage_line_o <= 1'b0;
				data_lines_oe_o <= 1'b0;
				busy_o <= 1'b0;
				done_o <= 1'b1;
				state_r <= S_IDLE;
			end
			default:
				state_r <= S_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// >>> testbench/prom_device_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Memory device on the far side of the pins
// ****************************************
module prom_device_model
#(
	parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h3c  // Arbitrary value
)
(
	input  wire logic        chip_sel_n_i, // Select
	input  wire logic        read_drv_n_i, // Read drive
	input  wire logic        vpp_high_i,   // Program supply
	input  wire logic        vcc_high_i,   // Core supply
	input  wire logic        id_line_i,    // Id line high
	input  wire logic [14:0] addr_i,       // Address
	input  wire logic [7:0]  data_i,       // Data wire level
	output var  logic [7:0]  data_o        // Data driven
);
	logic [7:0]  mem [0:32767];
	logic [7:0]  last;
	logic [14:0] last_a;
	int          hits;
	logic        drv;
	logic [7:0]  val;
	// Erased array; a byte needs two pulses, so retries are exercised
	initial
	begin
		foreach (mem[i]) mem[i] = 8'hff;
		last = 8'h00;
		last_a = 15'h0;
		hits = 0;
	end
	// End of a select pulse at high supply writes zeros only
	always @(posedge chip_sel_n_i)
		if (vpp_high_i === 1'b1)
		begin
			hits = (addr_i == last_a) ? hits + 1 : 1;
			last_a = addr_i;
			if (hits >= 2) mem[addr_i] = mem[addr_i] & data_i;
		end
	// Verify and signature reads; a released bus shows inverted stale data
	always @*
	begin
		drv = 1'b0;
		val = 8'h00;
		if (!read_drv_n_i && id_line_i && !chip_sel_n_i && !vpp_high_i && !vcc_high_i)
		begin
			drv = 1'b1;
			val = addr_i[0] ? DEV_CODE : MFR_CODE;
		end
		else if (!read_drv_n_i && chip_sel_n_i && vpp_high_i && vcc_high_i)
		begin
			drv = 1'b1;
			val = mem[addr_i];
		end
		if (drv) last = val;
		data_o = drv ? val : ~last;
	end
endmodule
`default_nettype wire

// >>> testbench/prom_programmer_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Pin timing checker
// ****************************************
module prom_programmer_assertions
(
	input wire logic        clk_i,        // Clock
	input wire logic        reset_i,      // Reset
	input wire logic        busy_o,       // Busy
	input wire logic        done_o,       // Done
	input wire logic        fail_o,       // Failed
	input wire logic [7:0]  pulses_o,     // Pulses
	input wire logic        chip_sel_n_o, // Select
	input wire logic        read_drv_n_o, // Read drive
	input wire logic [14:0] addr_o,       // Address
	input wire logic [7:0]  data_lines_o, // Data out
	input wire logic        data_lines_oe_o, // Data enable
	input wire logic        vpp_high_o,   // Program supply
	input wire logic        vcc_high_o,   // Core supply
	input wire logic        id_high_voltage_line_o // Id line
);
	logic [11:0] low_cnt_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Pulse length counter; too long for a repetition
	always @(posedge clk_i)
		low_cnt_r <= (reset_i || chip_sel_n_o) ? 12'h0 : low_cnt_r + 12'h1;
	a_pulse_width: assert property ($rose(chip_sel_n_o) && vpp_high_o |->
		low_cnt_r >= 12'd2375 && low_cnt_r <= 12'd2625) else $error("pulse width");
	a_setup_time: assert property ($fell(chip_sel_n_o) && vpp_high_o |->
		$past(vpp_high_o && vcc_high_o && data_lines_oe_o, 50)) else $error("setup");
	a_data_hold: assert property ($rose(chip_sel_n_o) && vpp_high_o |->
		(data_lines_oe_o && $stable(data_lines_o)) throughout (##49 1)) else $error("hold");
	a_verify_gap: assert property ($fell(read_drv_n_o) && vpp_high_o |->
		$past(chip_sel_n_o, 50)) else $error("verify gap");
	a_verify_mode: assert property (!read_drv_n_o && vpp_high_o |->
		chip_sel_n_o && vcc_high_o && !data_lines_oe_o) else $error("verify lines");
	a_program_mode: assert property (!chip_sel_n_o && vpp_high_o |->
		vcc_high_o && data_lines_oe_o && read_drv_n_o) else $error("program lines");
	a_signature_lines: assert property (id_high_voltage_line_o |->
		!vpp_high_o && !vcc_high_o && addr_o[14:1] == 14'h0) else $error("signature");
	a_pulse_cap: assert property (done_o && fail_o |-> pulses_o == 8'd25)
		else $error("cap");
	a_done_single: assert property (done_o |-> !busy_o ##1 !done_o)
		else $error("done");
	c_fail: cover property (done_o && fail_o);
	c_pulse: cover property ($rose(chip_sel_n_o) && vpp_high_o);
	c_sig: cover property (id_high_voltage_line_o && !read_drv_n_o);
endmodule
bind prom_programmer prom_programmer_assertions chk (.clk_i, .reset_i, .busy_o, .done_o,
	.fail_o, .pulses_o, .chip_sel_n_o, .read_drv_n_o, .addr_o, .data_lines_o,
	.data_lines_oe_o, .vpp_high_o, .vcc_high_o, .id_high_voltage_line_o);
`default_nettype wire

// >>> testbench/prom_programmer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Programmer bench
// ****************************************
module prom_programmer_tb_top;
	typedef struct {logic [1:0] op; logic [14:0] a; logic [7:0] d, rd, np; logic f;} row_t;
	logic clk_i = 0, reset_i = 1, start_i = 0;
	logic [1:0] op_i = 0;
	logic [14:0] addr_i = 0, addr_o;
	logic [7:0] wdata_i = 0, rdata_o, pulses_o, data_lines_o, dev_q, data_lines_i;
	logic busy_o, done_o, fail_o, chip_sel_n_o, read_drv_n_o, data_lines_oe_o;
	logic vpp_high_o, vcc_high_o, id_high_voltage_line_o;
	int errors = 0, checks_done = 0;
	// Signature, erased read, retried program, zero-to-one refusal, top address
	row_t rows [7] = '{'{2'h2, 15'h0, 8'h0, 8'h5a, 8'h0, 0}, '{2'h2, 15'h1, 8'h0, 8'h3c, 8'h0, 0},
		'{2'h1, 15'h10, 8'h0, 8'hff, 8'h0, 0}, '{2'h0, 15'h10, 8'ha5, 8'ha5, 8'h2, 0},
		'{2'h1, 15'h10, 8'h0, 8'ha5, 8'h0, 0}, '{2'h0, 15'h10, 8'hff, 8'ha5, 8'h19, 1},
		'{2'h0, 15'h7fff, 8'h00, 8'h00, 8'h2, 0}};
	// Wire level: whoever enables drives
	assign data_lines_i = data_lines_oe_o ? data_lines_o : dev_q;
	prom_programmer dut (.clk_i, .reset_i, .start_i, .op_i, .addr_i, .wdata_i, .busy_o,
		.done_o, .fail_o, .rdata_o, .pulses_o, .chip_sel_n_o, .read_drv_n_o, .addr_o,
		.data_lines_i, .data_lines_o, .data_lines_oe_o, .vpp_high_o, .vcc_high_o,
		.id_high_voltage_line_o);
	prom_device_model dev (.chip_sel_n_i(chip_sel_n_o), .read_drv_n_i(read_drv_n_o),
		.vpp_high_i(vpp_high_o), .vcc_high_i(vcc_high_o), .id_line_i(id_high_voltage_line_o),
		.addr_i(addr_o), .data_i(data_lines_i), .data_o(dev_q));
	initial
		forever #20 clk_i = ~clk_i;
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("errors=%0d checks=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One operation; waits for done under a bound
	task run_op(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		#1 start_i = 1;
		op_i = op;
		addr_i = a;
		wdata_i = d;
		@(posedge clk_i);
		#1 start_i = 0;
		for (n = 0; done_o !== 1'b1 && n < 70000; n++)
			@(posedge clk_i) #1;
		if (n >= 70000) errors++;
	endtask
	// Hang guard, longer than the whole sequence
	initial
	begin
		#4000000;
		errors++;
		tally_and_finish;
	end
	initial
	begin
		repeat (5) @(posedge clk_i);
		#1 reset_i = 0;
		foreach (rows[i])
		begin
			run_op(rows[i].op, rows[i].a, rows[i].d);
			check(rdata_o, rows[i].rd);
			check({7'h0, fail_o}, {7'h0, rows[i].f});
			if (rows[i].op == 2'h0) check(pulses_o, rows[i].np);
		end
		// Reset during a pulse must drop the program supply and release the wire
		@(posedge clk_i);
		#1 start_i = 1;
		op_i = 2'h0;
		addr_i = 15'h20;
		@(posedge clk_i);
		#1 start_i = 0;
		repeat (200) @(posedge clk_i);
		#1 reset_i = 1;
		repeat (2) @(posedge clk_i);
		#1 check({4'h0, busy_o, vpp_high_o, data_lines_oe_o, chip_sel_n_o}, 8'h01);
		check(rdata_o, 8'hff);
		reset_i = 0;
		run_op(2'h1, 15'h20, 8'h0);
		check(rdata_o, 8'hff);
		tally_and_finish;
	end
endmodule
`default_nettype wire
